// [icfu_top.sv]
// The register addresses and the APB interface to the registers are this design's own decisions.
module icfu_top
    import icfu_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter bit UNIT_IS_EVEN = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // capture pin and system state
    input wire logic capture_input,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    // time base ticks: timer1..timer5 in bits 0..4
    input wire logic [4:0] timer_tick,
    // sync and trigger sources, index 1..31
    input wire logic [31:1] sync_event,
    // cascade link from the odd partner (used by an even unit)
    input wire logic cas_roll_in,
    input wire logic cas_cap_in,
    input wire logic cas_clr_in,
    // cascade link to the even partner
    output logic cas_roll_out,
    output logic cas_cap_out,
    output logic cas_clr_out,
    // capture interrupt
    output logic capture_irq
);

    localparam int PW = $clog2(DEPTH);

    // ========================================================
    // configuration registers
    logic [2:0] capture_mode_sel_r;
    logic [1:0] captures_per_irq_r;
    logic [2:0] timebase_sel_r;
    logic idle_halt_r;
    logic [4:0] sync_source_sel_r;
    logic trigger_not_sync_r;
    logic trigger_status_r;
    logic cascade_en_r;
    logic capture_overflow_r;
    logic armed_r;

    logic [15:0] capture_counter_r;
    logic pin_prev_r;
    logic [3:0] presc_r;
    logic [1:0] pace_r;

    logic [15:0] fifo_mem [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] fill_r;
    logic pop_pending_r;

    // ========================================================
    // mode decode
    logic slave;
    logic mode_on;
    logic halted;
    logic src_zero;
    logic sync_hit;
    logic sync_mode;
    logic hold_zero;
    logic clr_cond;
    logic tick;
    logic run;
    logic rise;
    logic fall;
    logic cap_evt;
    logic push;
    logic pop;
    logic fifo_full;
    logic fifo_empty;
    logic setup;
    logic access;
    logic wr_c1;
    logic wr_c2;

    function automatic logic tb_pick(input logic [2:0] sel, input logic [4:0] t);
        case (sel)
            ICFU_TB_TIMER3: tb_pick = t[2];
            ICFU_TB_TIMER2: tb_pick = t[1];
            ICFU_TB_TIMER4: tb_pick = t[3];
            ICFU_TB_TIMER5: tb_pick = t[4];
            ICFU_TB_TIMER1: tb_pick = t[0];
            ICFU_TB_PERIPH: tb_pick = 1'b1;
            default: tb_pick = 1'b0;
        endcase
    endfunction

    assign slave = UNIT_IS_EVEN && cascade_en_r;
    assign mode_on = (capture_mode_sel_r != ICFU_MODE_OFF) &&
                     (capture_mode_sel_r != ICFU_MODE_UNUSED) &&
                     (capture_mode_sel_r != ICFU_MODE_WAKE_IRQ);
    // idle halt freezes counter and capture, it does not clear them
    assign halted = idle_halt_r && cpu_idle;
    assign src_zero = (sync_source_sel_r == ICFU_SYNC_OFF);
    // source 0 has no event line; the guard keeps that index out of play
    assign sync_hit = !src_zero && sync_event[sync_source_sel_r];
    assign sync_mode = !src_zero && !trigger_not_sync_r;
    assign hold_zero = !mode_on || (trigger_not_sync_r && !trigger_status_r) ||
                       (sync_mode && cascade_en_r && !armed_r);
    assign clr_cond = slave ? cas_clr_in : (hold_zero || (sync_mode && sync_hit));
    // an even unit in cascade counts the odd unit's wraps, not its own time base
    assign tick = slave ? cas_roll_in : (tb_pick(timebase_sel_r, timer_tick) && !halted);
    assign run = !clr_cond && tick;

    assign rise = capture_input && !pin_prev_r;
    assign fall = !capture_input && pin_prev_r;

    always_comb begin
        cap_evt = 1'b0;
        if (slave) begin
            cap_evt = cas_cap_in;
        end else if (!hold_zero && !halted) begin
            case (capture_mode_sel_r)
                ICFU_MODE_EVERY_EDGE: cap_evt = rise || fall;
                ICFU_MODE_FALL: cap_evt = fall;
                ICFU_MODE_RISE: cap_evt = rise;
                ICFU_MODE_RISE_4: cap_evt = rise && (presc_r[1:0] == ICFU_PRESC_4_LAST[1:0]);
                ICFU_MODE_RISE_16: cap_evt = rise && (presc_r == ICFU_PRESC_16_LAST);
                default: cap_evt = 1'b0;
            endcase
        end
    end

    assign fifo_full = (fill_r == (PW + 1)'(DEPTH));
    assign fifo_empty = (fill_r == '0);
    assign push = cap_evt && !fifo_full;
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    // the pop lands at the access edge, matching the value latched at setup
    assign pop = access && pop_pending_r;
    // writes land at the same access edge
    assign wr_c1 = access && pwrite && (paddr == ICFU_OFS_CTRL1);
    assign wr_c2 = access && pwrite && (paddr == ICFU_OFS_CTRL2);

    // ========================================================
    // configuration writes
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            capture_mode_sel_r <= ICFU_C1_RESET[ICFU_C1_MODE_LSB +: 3];
            captures_per_irq_r <= ICFU_C1_RESET[ICFU_C1_PACE_LSB +: 2];
            timebase_sel_r <= ICFU_C1_RESET[ICFU_C1_TB_LSB +: 3];
            idle_halt_r <= ICFU_C1_RESET[ICFU_C1_IDLE_HALT];
        end else if (wr_c1) begin
            capture_mode_sel_r <= pwdata[ICFU_C1_MODE_LSB +: 3];
            captures_per_irq_r <= pwdata[ICFU_C1_PACE_LSB +: 2];
            timebase_sel_r <= pwdata[ICFU_C1_TB_LSB +: 3];
            idle_halt_r <= pwdata[ICFU_C1_IDLE_HALT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sync_source_sel_r <= ICFU_SYNC_SEL_RESET;
            trigger_not_sync_r <= 1'b0;
            cascade_en_r <= 1'b0;
        end else if (wr_c2) begin
            sync_source_sel_r <= pwdata[ICFU_C2_SYNC_LSB +: 5];
            trigger_not_sync_r <= pwdata[ICFU_C2_TRIG_NOT_SYNC];
            cascade_en_r <= pwdata[ICFU_C2_CASCADE];
        end
    end

    // trigger status: hardware or software set, software clear; set wins
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            trigger_status_r <= 1'b0;
        end else if (mode_on && trigger_not_sync_r && sync_hit) begin
            trigger_status_r <= 1'b1;
        end else if (wr_c2) begin
            trigger_status_r <= pwdata[ICFU_C2_TRIG_STATUS];
        end
    end

    // cascaded sync units stay in reset until the first sync event
    always_ff @(posedge ref_clk) begin
        if (!nrst || !mode_on || !cascade_en_r) begin
            armed_r <= 1'b0;
        end else if (sync_hit) begin
            armed_r <= 1'b1;
        end
    end

    // ========================================================
    // counter
    always_ff @(posedge ref_clk) begin
        if (!nrst || clr_cond) begin
            capture_counter_r <= '0;
        end else if (tick) begin
            capture_counter_r <= capture_counter_r + 16'h0001;
        end
    end

    // cascade link to the even partner, registered one cycle behind; the even unit uses it unregistered
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cas_roll_out <= 1'b0;
            cas_cap_out <= 1'b0;
            cas_clr_out <= 1'b1;
        end else begin
            cas_roll_out <= run && (capture_counter_r == ICFU_CNT_MAX);
            cas_cap_out <= cap_evt;
            cas_clr_out <= clr_cond;
        end
    end

    // ========================================================
    // edge detection and prescaler
    // previous sample resets low, the idle level of the pin, so no false edge
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= capture_input;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || !mode_on) begin
            presc_r <= '0;
        end else if (rise && !hold_zero && !halted) begin
            presc_r <= presc_r + 4'h1;
        end
    end

    // ========================================================
    // capture FIFO
    // storage needs no reset: pointers and fill count decide what is valid
    always_ff @(posedge ref_clk) begin
        if (push) begin
            fifo_mem[wr_ptr_r] <= capture_counter_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || (!mode_on && !slave)) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            fill_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
            end
            fill_r <= fill_r + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end

    // overflow: capture into a full FIFO sets it; emptying by read clears it
    always_ff @(posedge ref_clk) begin
        if (!nrst || (!mode_on && !slave)) begin
            capture_overflow_r <= 1'b0;
        end else if (cap_evt && fifo_full) begin
            capture_overflow_r <= 1'b1;
        end else if (pop && fill_r == (PW + 1)'(1) && !push) begin
            capture_overflow_r <= 1'b0;
        end
    end

    // ========================================================
    // interrupt pacing and wake interrupt
    // the wake interrupt needs no running counter, so it skips mode_on
    always_ff @(posedge ref_clk) begin
        if (!nrst || !mode_on || slave) begin
            pace_r <= '0;
        end else if (cap_evt) begin
            pace_r <= (pace_r == captures_per_irq_r) ? 2'h0 : pace_r + 2'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || slave) begin
            capture_irq <= 1'b0;
        end else if (capture_mode_sel_r == ICFU_MODE_WAKE_IRQ) begin
            capture_irq <= rise && (cpu_idle || cpu_sleep);
        end else if (capture_mode_sel_r == ICFU_MODE_EVERY_EDGE) begin
            capture_irq <= cap_evt;
        end else begin
            capture_irq <= cap_evt && (pace_r == captures_per_irq_r);
        end
    end

    // ========================================================
    // apb slave: answers in the first access cycle
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
            pop_pending_r <= 1'b0;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            prdata <= '0;
            pop_pending_r <= 1'b0;
            case (paddr)
                ICFU_OFS_CTRL1: begin
                    if (!pwrite) begin
                        prdata[ICFU_C1_MODE_LSB +: 3] <= capture_mode_sel_r;
                        prdata[ICFU_C1_NOT_EMPTY] <= !fifo_empty;
                        prdata[ICFU_C1_OVERFLOW] <= capture_overflow_r;
                        prdata[ICFU_C1_PACE_LSB +: 2] <= captures_per_irq_r;
                        prdata[ICFU_C1_TB_LSB +: 3] <= timebase_sel_r;
                        prdata[ICFU_C1_IDLE_HALT] <= idle_halt_r;
                    end
                end
                ICFU_OFS_CTRL2: begin
                    if (!pwrite) begin
                        prdata[ICFU_C2_SYNC_LSB +: 5] <= sync_source_sel_r;
                        prdata[ICFU_C2_TRIG_STATUS] <= trigger_status_r;
                        prdata[ICFU_C2_TRIG_NOT_SYNC] <= trigger_not_sync_r;
                        prdata[ICFU_C2_CASCADE] <= cascade_en_r;
                    end
                end
                ICFU_OFS_FIFO: begin
                    if (!pwrite && !fifo_empty) begin
                        prdata[15:0] <= fifo_mem[rd_ptr_r];
                        pop_pending_r <= 1'b1;
                    end
                end
                ICFU_OFS_COUNTER: begin
                    if (!pwrite) begin
                        prdata[15:0] <= capture_counter_r;
                    end
                end
                default: pslverr <= 1'b1;
            endcase
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            pop_pending_r <= 1'b0;
        end
    end

endmodule

// [icfu_pkg.sv]
package icfu_pkg;

    // ========================================================
    // register byte offsets
    localparam logic [11:0] ICFU_OFS_CTRL1 = 12'h000;
    localparam logic [11:0] ICFU_OFS_CTRL2 = 12'h004;
    localparam logic [11:0] ICFU_OFS_FIFO = 12'h008;
    localparam logic [11:0] ICFU_OFS_COUNTER = 12'h00C;

    // ========================================================
    // capture_control_one fields
    localparam int ICFU_C1_MODE_LSB = 0;
    localparam int ICFU_C1_NOT_EMPTY = 3;
    localparam int ICFU_C1_OVERFLOW = 4;
    localparam int ICFU_C1_PACE_LSB = 5;
    localparam int ICFU_C1_TB_LSB = 10;
    localparam int ICFU_C1_IDLE_HALT = 13;

    // ========================================================
    // capture_control_two fields
    localparam int ICFU_C2_SYNC_LSB = 0;
    localparam int ICFU_C2_TRIG_STATUS = 6;
    localparam int ICFU_C2_TRIG_NOT_SYNC = 7;
    localparam int ICFU_C2_CASCADE = 8;

    // ========================================================
    // reset values
    localparam logic [15:0] ICFU_C1_RESET = 16'h0000;
    localparam logic [4:0] ICFU_SYNC_SEL_RESET = 5'h0D;
    localparam logic [4:0] ICFU_SYNC_OFF = 5'h00;

    // ========================================================
    // capture modes
    localparam logic [2:0] ICFU_MODE_OFF = 3'h0;
    localparam logic [2:0] ICFU_MODE_EVERY_EDGE = 3'h1;
    localparam logic [2:0] ICFU_MODE_FALL = 3'h2;
    localparam logic [2:0] ICFU_MODE_RISE = 3'h3;
    localparam logic [2:0] ICFU_MODE_RISE_4 = 3'h4;
    localparam logic [2:0] ICFU_MODE_RISE_16 = 3'h5;
    localparam logic [2:0] ICFU_MODE_UNUSED = 3'h6;
    localparam logic [2:0] ICFU_MODE_WAKE_IRQ = 3'h7;

    // ========================================================
    // time base codes
    localparam logic [2:0] ICFU_TB_TIMER3 = 3'h0;
    localparam logic [2:0] ICFU_TB_TIMER2 = 3'h1;
    localparam logic [2:0] ICFU_TB_TIMER4 = 3'h2;
    localparam logic [2:0] ICFU_TB_TIMER5 = 3'h3;
    localparam logic [2:0] ICFU_TB_TIMER1 = 3'h4;
    localparam logic [2:0] ICFU_TB_PERIPH = 3'h7;

    // ========================================================
    // counts
    localparam logic [15:0] ICFU_CNT_MAX = 16'hFFFF;
    localparam logic [3:0] ICFU_PRESC_4_LAST = 4'h3;
    localparam logic [3:0] ICFU_PRESC_16_LAST = 4'hF;

endpackage

// [icfu_assertions.sv]
module icfu_assertions
    import icfu_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // capture pin
    input wire logic capture_input,
    // unit outputs
    input wire logic cas_roll_out,
    input wire logic cas_clr_out,
    input wire logic capture_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // ========================================================
    // mode as last written by software
    logic [2:0] mode_r;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mode_r <= ICFU_MODE_OFF;
        end else if (psel && penable && pready && pwrite && paddr == ICFU_OFS_CTRL1) begin
            mode_r <= pwdata[2:0];
        end
    end
    logic off_settled;
    assign off_settled = mode_r == ICFU_MODE_OFF;

    // ========================================================
    // properties
    property p_reset_out;
        $rose(nrst) |-> !pready && !capture_irq && cas_clr_out;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not at reset value");
    property p_rdy_after_setup;
        psel && !penable |=> pready;
    endproperty
    a_rdy_after_setup: assert property (p_rdy_after_setup) else $error("no ready after setup");
    property p_rdy_one;
        pready |=> !pready;
    endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
    property p_rdy_cause;
        pready |-> $past(psel) && !$past(penable);
    endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("ready without setup");
    property p_err;
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_err: assert property (p_err) else $error("error without ready or with data");
    property p_irq_pulse;
        capture_irq |-> $past(capture_input) != $past(capture_input, 2);
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq without a pin edge");
    property p_roll_pulse;
        cas_roll_out |=> !cas_roll_out [*8];
    endproperty
    a_roll_pulse: assert property (p_roll_pulse) else $error("wrap pulse repeats");
    property p_off_no_irq;
        off_settled && $past(off_settled) && $past(off_settled, 2) |-> !capture_irq;
    endproperty
    a_off_no_irq: assert property (p_off_no_irq) else $error("irq while off");
    property p_off_clr;
        off_settled && $past(off_settled) && $past(off_settled, 2) |-> cas_clr_out;
    endproperty
    a_off_clr: assert property (p_off_clr) else $error("counter not held while off");

    c_irq: cover property (capture_irq);
    c_roll: cover property (cas_roll_out);
    c_err: cover property (pslverr);
endmodule

bind icfu_top icfu_assertions u_chk (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input(capture_input),
    .cas_roll_out(cas_roll_out), .cas_clr_out(cas_clr_out), .capture_irq(capture_irq));

// [icfu_pulse_model.sv]
module icfu_pulse_model (
    // clock
    input wire logic ref_clk,
    // capture pin and sync sources
    output logic pin,
    output logic [31:1] sync_event
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pin = 1'b0;
        sync_event = '0;
    end
    // one pulse: high for hi cycles, then low for lo cycles
    task automatic pulse(input int hi, input int lo);
        @(posedge ref_clk);
        pin <= 1'b1;
        repeat (hi) @(posedge ref_clk);
        pin <= 1'b0;
        repeat (lo) @(posedge ref_clk);
    endtask
    // one-cycle event on the chosen sync source
    task automatic sync(input int idx);
        @(posedge ref_clk);
        sync_event[idx] <= 1'b1;
        @(posedge ref_clk);
        sync_event <= '0;
    endtask
endmodule

// [icfu_tb.sv]
module tb
    import icfu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, cpu_idle = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, prev;
    logic pready, pslverr, capture_input, capture_irq, roll, cap, er;
    logic cpu_sleep = 0;
    logic [4:0] timer_tick = '0;
    logic [31:1] sync_event;
    int num_errors = 0, tests_run = 0, irq_cnt = 0, roll_cnt = 0, g;
    int cap_cnt = 0, tk_cnt = 0;
    int q[$];
    logic [15:0] cfg[11] = '{16'h1C01, 16'h1C02, 16'h1C03, 16'h1C04, 16'h1C05, 16'h1C00,
        16'h1C06, 16'h1C07, 16'h1C23, 16'h1C63, 16'h1C43};

    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        timer_tick <= 5'($urandom);
        if (capture_irq === 1'b1) irq_cnt++;
        if (roll === 1'b1) roll_cnt++;
        if (cap === 1'b1) cap_cnt++;
        if (timer_tick[2] && !cpu_idle) tk_cnt++;
    end

    icfu_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .capture_input(capture_input), .cpu_idle(cpu_idle),
        .cpu_sleep(cpu_sleep), .timer_tick(timer_tick), .sync_event(sync_event),
        .cas_roll_in(1'b0), .cas_cap_in(1'b0), .cas_clr_in(1'b0), .cas_roll_out(roll),
        .cas_cap_out(cap), .cas_clr_out(), .capture_irq(capture_irq));
    icfu_pulse_model u_src (.ref_clk(ref_clk), .pin(capture_input), .sync_event(sync_event));

    // ========================================================
    // bus, compare and closing
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // captures and interrupts for 16 pulses under one setting, device asleep
    function automatic int model_cap(input logic [15:0] c);
        case (c[2:0])
            ICFU_MODE_EVERY_EDGE: return 32;
            ICFU_MODE_FALL, ICFU_MODE_RISE: return 16;
            ICFU_MODE_RISE_4: return 4;
            ICFU_MODE_RISE_16: return 1;
            default: return 0;
        endcase
    endfunction
    function automatic int model_irq(input logic [15:0] c);
        case (c[2:0])
            ICFU_MODE_EVERY_EDGE: return 32;
            ICFU_MODE_WAKE_IRQ: return 16;
            default: return model_cap(c) / (int'(c[6:5]) + 1);
        endcase
    endfunction

    initial begin
        repeat (95000) @(posedge ref_clk);
        num_errors++;
        finish_test();
    end

    // ========================================================
    // main sequence
    initial begin
        void'($urandom(32'h5abd22f1));
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        apb(1'b0, ICFU_OFS_CTRL1, 32'h0);
        chk("ctrl1 reset", {16'h0, ICFU_C1_RESET}, rd);
        apb(1'b0, ICFU_OFS_CTRL2, 32'h0);
        chk("ctrl2 reset", 32'h0000_000D, rd);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        // fill past four, then drain in order
        apb(1'b1, ICFU_OFS_CTRL2, 32'h0);
        apb(1'b1, ICFU_OFS_CTRL1, 32'h1C03);
        for (int i = 0; i < 5; i++) begin
            g = 8 + $urandom_range(15);
            q.push_back(g + 5);
            u_src.pulse(4, g);
        end
        apb(1'b0, ICFU_OFS_CTRL1, 32'h0);
        chk("full flags", 32'h18, rd & 32'h18);
        apb(1'b0, ICFU_OFS_FIFO, 32'h0);
        prev = rd;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, ICFU_OFS_FIFO, 32'h0);
            chk("capture spacing", 32'(q[i]), (rd - prev) & 32'hFFFF);
            prev = rd;
        end
        apb(1'b0, ICFU_OFS_CTRL1, 32'h0);
        chk("drained flags", 32'h0, rd & 32'h18);
        apb(1'b0, ICFU_OFS_FIFO, 32'h0);
        chk("empty read", 32'h0, rd);
        // sync restarts the counter
        apb(1'b1, ICFU_OFS_CTRL2, 32'h5);
        repeat (2) begin
            u_src.sync(5);
            u_src.pulse(4, 9);
        end
        apb(1'b0, ICFU_OFS_FIFO, 32'h0);
        prev = rd;
        apb(1'b0, ICFU_OFS_FIFO, 32'h0);
        chk("sync restart", 32'h0, rd - prev);
        // hardware trigger, then software trigger
        apb(1'b1, ICFU_OFS_CTRL1, 32'h0);
        apb(1'b1, ICFU_OFS_CTRL2, 32'h85);
        apb(1'b1, ICFU_OFS_CTRL1, 32'h1C03);
        u_src.pulse(4, 4);
        apb(1'b0, ICFU_OFS_CTRL1, 32'h0);
        chk("held before trigger", 32'h0, rd & 32'h8);
        apb(1'b0, ICFU_OFS_CTRL2, 32'h0);
        chk("status before trigger", 32'h0, rd & 32'h40);
        u_src.sync(5);
        apb(1'b0, ICFU_OFS_CTRL2, 32'h0);
        chk("status after trigger", 32'h40, rd & 32'h40);
        u_src.pulse(4, 4);
        apb(1'b0, ICFU_OFS_CTRL1, 32'h0);
        chk("capture after trigger", 32'h8, rd & 32'h8);
        apb(1'b1, ICFU_OFS_CTRL2, 32'h80);
        apb(1'b0, ICFU_OFS_CTRL2, 32'h0);
        chk("soft trigger idle", 32'h0, rd & 32'h40);
        apb(1'b1, ICFU_OFS_CTRL2, 32'hC0);
        apb(1'b0, ICFU_OFS_CTRL2, 32'h0);
        chk("soft trigger set", 32'h40, rd & 32'h40);
        // modes and pacing, fifo kept drained
        cpu_sleep <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            apb(1'b1, ICFU_OFS_CTRL1, 32'h0);
            apb(1'b1, ICFU_OFS_CTRL1, {16'h0, cfg[i]});
            irq_cnt = 0;
            cap_cnt = 0;
            repeat (16) begin
                u_src.pulse(4, 4);
                apb(1'b0, ICFU_OFS_FIFO, 32'h0);
                apb(1'b0, ICFU_OFS_FIFO, 32'h0);
            end
            repeat (4) @(posedge ref_clk);
            chk("irq count", 32'(model_irq(cfg[i])), 32'(irq_cnt));
            chk("capture count", 32'(model_cap(cfg[i])), 32'(cap_cnt));
        end
        cpu_sleep <= 1'b0;
        // idle halt
        apb(1'b1, ICFU_OFS_CTRL2, 32'h0);
        apb(1'b1, ICFU_OFS_CTRL1, 32'h0);
        apb(1'b1, ICFU_OFS_CTRL1, 32'h3C03);
        cpu_idle <= 1'b1;
        u_src.pulse(4, 4);
        apb(1'b0, ICFU_OFS_CTRL1, 32'h0);
        chk("idle halt", 32'h0, rd & 32'h8);
        cpu_idle <= 1'b0;
        u_src.pulse(4, 4);
        apb(1'b0, ICFU_OFS_CTRL1, 32'h0);
        chk("idle resume", 32'h8, rd & 32'h8);
        // counter on timer 3 ticks, frozen by idle halt
        apb(1'b1, ICFU_OFS_CTRL1, 32'h0);
        apb(1'b1, ICFU_OFS_CTRL1, 32'h2003);
        @(negedge ref_clk);
        tk_cnt = 0;
        repeat (50) @(posedge ref_clk);
        cpu_idle <= 1'b1;
        apb(1'b0, ICFU_OFS_COUNTER, 32'h0);
        chk("timer3 count", 32'(tk_cnt), rd);
        cpu_idle <= 1'b0;
        // one wrap in a full counter period
        apb(1'b1, ICFU_OFS_CTRL1, 32'h1C03);
        @(negedge ref_clk);
        roll_cnt = 0;
        repeat (65536) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("wraps per period", 32'h1, 32'(roll_cnt));
        finish_test();
    end
endmodule
